// *** src/fis_pkg.sv ***
// Notes on behaviour
// - 9Fh returns maker, type, capacity bytes
// - id read not decoded while busy
// - select rise stops output, standby
// - 4Bh, dummy bytes, then 128-bit number
// - B9h only if select rises at bit 8
// - sleep entered within entry delay
// - in sleep only wake and reset
// - plain wake blocks commands for delay
// - ABh with dummies repeats device code
// - wake with code uses longer delay
// - ABh ignored while busy
// - 48h, address, dummy, advancing bytes
// - byte offset wraps 3FFh to 000h
// - three 1024-byte regions, bits 15:12
// - four-line read dummies follow setting
// - 44h erase needs latch, rise at bit 8
// - busy during cycle, latch cleared
// - any lock blocks erase forever
// - 42h program, up to 256 bytes each
// - region lock blocks program forever
// - 5Ah, 24-bit address, dummy clocks
// - four-line dummies default 4, up to 10
// - latch gates writes, status shows busy
package fis_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS / CLK_PERIOD_NS;
  localparam int WAKE_NS = 3000;
  localparam int WAKE_CYC = WAKE_NS / CLK_PERIOD_NS;
  localparam int WAKE_CODE_NS = 8000;
  localparam int WAKE_CODE_CYC = WAKE_CODE_NS / CLK_PERIOD_NS;
  localparam int ERASE_US = 100000;
  localparam int ERASE_CYC = ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int PROGRAM_US = 1000;
  localparam int PROGRAM_CYC = PROGRAM_US * 1000 / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_READ_ID = 8'h9f;
  localparam logic [7:0] OP_UNIQUE = 8'h4b;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_PARAM_READ = 8'h5a;
  localparam logic [7:0] OP_SET_PARAMS = 8'hc0;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  // ------------------------------------------------------------
  // frame bit positions, counted in bits on the lines
  // ------------------------------------------------------------
  localparam logic [15:0] OPC_END = 16'h0008;
  localparam logic [15:0] PRM_END = 16'h0010;
  localparam logic [15:0] ADR_END = 16'h0020;
  localparam logic [15:0] DATA_START = 16'h0028;
  localparam logic [15:0] DUMMY_SINGLE = 16'h0008;
  localparam logic [15:0] DUMMY_QUAD_BASE = 16'h0010;
  // ------------------------------------------------------------
  // region map, status, reset values
  // ------------------------------------------------------------
  localparam logic [3:0] REGION_FIRST = 4'h1;
  localparam logic [3:0] REGION_LAST = 4'h3;
  localparam int MEM_WORDS = 3072;
  localparam logic [11:0] MEM_LAST = 12'hbff;
  localparam logic [1:0] DUMMY_SEL_RST = 2'h0;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [127:0] PARAM_TABLE = 128'h53464450_00010001_00000000_ffffffff;
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_SLEEP = 2'b10,
    PWR_WAKING = 2'b11
  } fis_pwr_e;
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_ERASE = 2'b01,
    CYC_PROG = 2'b10
  } fis_cyc_e;
endpackage

// *** src/fis_flash_cmd.sv ***
`timescale 1ns/10ps
`default_nettype none
module fis_flash_cmd #(
  parameter int ERASE_CYCLES = fis_pkg::ERASE_CYC,
  parameter int PROGRAM_CYCLES = fis_pkg::PROGRAM_CYC,
  parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h41, // arbitrary value
  parameter logic [7:0] CAPACITY = 8'h15, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h27, // arbitrary value
  parameter logic [127:0] UNIQUE_NUM = 128'h0123456789abcdef_fedcba9876543210
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // configuration and lock sources
  input wire logic four_line_command_mode,
  input wire logic [2:0] otp_lock_in,
  input wire logic [2:0] lock_set,
  // status
  output logic busy_flag,
  output logic write_unlock_latch,
  output logic deep_sleep_state,
  output logic [2:0] per_region_lock_bits,
  output logic secure_area_lock
);
  import fis_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_ff; // release chain
  logic rst_n; // released copy for all logic
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // core state flops, declared early for the link side
  fis_pwr_e pwr_ff, nxt_pwr;
  fis_cyc_e cyc_ff, nxt_cyc;
  logic busy_ff, wel_ff, sleep_ff, blk_ff, waking_ff, secure_ff;
  logic [1:0] sel_ff; // four-line dummy selection
  logic [2:0] lock_ff;
  logic [7:0] mem_ff [0:MEM_WORDS-1]; // three secure regions

  // ------------------------------------------------------------
  // link side, on sclk
  // ------------------------------------------------------------
  logic [6:0] lk_s1_ff, lk_s2_ff; // core levels into sclk
  logic frame_new_ff; // set while select is high
  logic [15:0] bit_cnt_ff; // bits taken this frame
  logic [31:0] shift_ff;
  logic [7:0] op_ff, param_ff, wr_data_ff;
  logic [23:0] addr_ff;
  logic [9:0] wr_off_ff;
  logic wr_tgl_ff; // flips per program byte
  logic [3:0] io_out_ff, io_oe_ff;

  // levels change at select rise, or for busy, waking and blk when the timer ends; two edges give settled copies
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      lk_s1_ff <= 7'h00;
      lk_s2_ff <= 7'h00;
    end else begin
      lk_s1_ff <= {four_line_command_mode, wel_ff, busy_ff, sel_ff, blk_ff, waking_ff};
      lk_s2_ff <= lk_s1_ff;
    end
  end

  logic quad_l, wel_l, busy_l, blk_l, waking_l;
  logic [1:0] sel_l;
  assign {quad_l, wel_l, busy_l, sel_l, blk_l, waking_l} = lk_s2_ff;

  // first edge of a frame restarts counting without needing cs_n edges
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      frame_new_ff <= 1'b1;
    end else begin
      frame_new_ff <= 1'b0;
    end
  end

  logic [15:0] step_l, nxt_cnt, pos_l, out_start, dummy_l;
  logic [31:0] nxt_shift;
  logic [7:0] prog_idx;
  always_comb begin
    step_l = quad_l ? 16'h0004 : 16'h0001;
    nxt_cnt = frame_new_ff ? step_l : bit_cnt_ff + step_l;
    // msb arrives first on every line
    nxt_shift = quad_l ? {shift_ff[27:0], io_in} : {shift_ff[30:0], io_in[0]};
    prog_idx = nxt_cnt[10:3] - DATA_START[10:3];
  end

  // opcode, address and data capture on rising edges
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff <= 16'h0000;
      shift_ff <= 32'h0;
      op_ff <= 8'h00;
      param_ff <= 8'h00;
      addr_ff <= 24'h0;
      wr_data_ff <= 8'h00;
      wr_off_ff <= 10'h000;
      wr_tgl_ff <= 1'b0;
    end else begin
      bit_cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      if (nxt_cnt == OPC_END) begin
        op_ff <= nxt_shift[7:0];
      end
      if (nxt_cnt == PRM_END) begin
        param_ff <= nxt_shift[7:0];
      end
      if (nxt_cnt == ADR_END) begin
        addr_ff <= nxt_shift[23:0];
      end
      // each whole data byte is handed to the core with a toggle
      if (op_ff == OP_SEC_PROG && nxt_cnt >= DATA_START && nxt_cnt[2:0] == 3'h0) begin
        wr_data_ff <= nxt_shift[7:0];
        wr_off_ff <= {addr_ff[9:8], addr_ff[7:0] + prog_idx};
        wr_tgl_ff <= ~wr_tgl_ff;
      end
    end
  end

  // what the current opcode may send and from which bit on
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b0;
    out_start = OPC_END;
    dummy_l = quad_l ? DUMMY_QUAD_BASE + {11'h000, sel_l, 3'h0} : DUMMY_SINGLE;
    case (op_ff)
      OP_READ_ID: rd_ok = !busy_l && !blk_l;
      OP_STATUS: rd_ok = !blk_l;
      OP_UNIQUE: begin
        rd_ok = !quad_l && !blk_l;
        out_start = DATA_START;
      end
      OP_WAKE: begin
        rd_ok = !busy_l;
        out_start = ADR_END;
      end
      OP_SEC_READ, OP_PARAM_READ: begin
        rd_ok = !blk_l;
        out_start = ADR_END + dummy_l;
      end
      default: rd_ok = 1'b0;
    endcase
    // nothing is answered until the wake delay is over
    if (waking_l) begin
      rd_ok = 1'b0;
    end
  end

  // byte being sent and its bit or nibble
  logic [7:0] out_byte;
  logic [9:0] rd_off;
  logic [11:0] rd_idx;
  logic [127:0] uid_sh, tbl_sh;
  logic rd_region_ok;
  always_comb begin
    pos_l = bit_cnt_ff - out_start;
    rd_off = addr_ff[9:0] + pos_l[12:3];
    rd_idx = {addr_ff[13:12] - 2'h1, rd_off};
    rd_region_ok = addr_ff[23:16] == 8'h00 && addr_ff[11:10] == 2'h0 &&
      addr_ff[15:12] >= REGION_FIRST && addr_ff[15:12] <= REGION_LAST;
    uid_sh = UNIQUE_NUM << {pos_l[6:3], 3'h0};
    tbl_sh = PARAM_TABLE << {addr_ff[3:0] + pos_l[6:3], 3'h0};
    case (op_ff)
      OP_READ_ID: begin
        // three bytes, then a blank byte, repeating
        case (pos_l[4:3])
          2'h0: out_byte = MAKER_CODE;
          2'h1: out_byte = MEM_TYPE;
          2'h2: out_byte = CAPACITY;
          default: out_byte = 8'h00;
        endcase
      end
      OP_UNIQUE: out_byte = uid_sh[127:120];
      OP_WAKE: out_byte = DEVICE_CODE;
      OP_STATUS: out_byte = {6'h00, wel_l, busy_l};
      // contents can change during a read: 48h ignores busy, and the erase sweep writes while busy
      OP_SEC_READ: out_byte = rd_region_ok ? mem_ff[rd_idx] : ERASED;
      OP_PARAM_READ: out_byte = tbl_sh[127:120];
      default: out_byte = 8'h00;
    endcase
  end

  // falling-edge drive; select high releases the lines at once
  always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      io_out_ff <= 4'h0;
      io_oe_ff <= 4'h0;
    end else if (cs_n) begin
      io_out_ff <= 4'h0;
      io_oe_ff <= 4'h0;
    end else if (rd_ok && !frame_new_ff && bit_cnt_ff >= out_start) begin
      if (quad_l) begin
        io_out_ff <= pos_l[2] ? out_byte[3:0] : out_byte[7:4];
        io_oe_ff <= 4'hf;
      end else begin
        io_out_ff <= {2'h0, out_byte[~pos_l[2:0]], 1'b0};
        io_oe_ff <= 4'h2;
      end
    end else begin
      io_out_ff <= 4'h0;
      io_oe_ff <= 4'h0;
    end
  end
  assign io_out = io_out_ff;
  assign io_oe = io_oe_ff;

  // ------------------------------------------------------------
  // core side, on core_clk
  // ------------------------------------------------------------
  logic [2:0] cs_sync_ff, tgl_sync_ff; // two sync stages plus history
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_ff <= 3'b111;
      tgl_sync_ff <= 3'b000;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], cs_n};
      tgl_sync_ff <= {tgl_sync_ff[1:0], wr_tgl_ff};
    end
  end

  // link words are held still while select is high, so read directly
  logic cs_rise, tgl_edge;
  assign cs_rise = cs_sync_ff[1] && !cs_sync_ff[2];
  assign tgl_edge = tgl_sync_ff[1] ^ tgl_sync_ff[2];

  // frame decode at select rise
  logic go_sleep, go_wake, go_wake_code, go_erase, go_prog;
  logic set_wel, clr_wel, set_sel, arm_rst, do_rst, rst_arm_ff;
  logic op8, idle_ok, prog_len_ok, reg_ok;
  logic [1:0] reg_n;
  always_comb begin
    go_sleep = 1'b0;
    go_wake = 1'b0;
    go_wake_code = 1'b0;
    go_erase = 1'b0;
    go_prog = 1'b0;
    set_wel = 1'b0;
    clr_wel = 1'b0;
    set_sel = 1'b0;
    arm_rst = 1'b0;
    do_rst = 1'b0;
    op8 = bit_cnt_ff == OPC_END;
    idle_ok = cyc_ff == CYC_IDLE;
    prog_len_ok = bit_cnt_ff >= DATA_START && bit_cnt_ff[2:0] == 3'h0;
    reg_n = addr_ff[13:12] - 2'h1;
    reg_ok = rd_region_ok && !lock_ff[reg_n];
    if (cs_rise && pwr_ff != PWR_WAKING) begin
      arm_rst = op_ff == OP_RST_EN && op8;
      do_rst = op_ff == OP_RST && op8 && rst_arm_ff;
      if (pwr_ff != PWR_ACTIVE) begin
        // only the wake opcode and the reset pair are seen here
        if (op_ff == OP_WAKE && idle_ok) begin
          go_wake = op8;
          go_wake_code = bit_cnt_ff >= ADR_END;
        end
      end else begin
        case (op_ff)
          OP_SLEEP: go_sleep = op8 && idle_ok;
          OP_SEC_ERASE: go_erase = op8 && idle_ok && wel_ff && !secure_ff;
          OP_SEC_PROG: go_prog = prog_len_ok && idle_ok && wel_ff && reg_ok;
          OP_WR_EN: set_wel = op8 && idle_ok;
          OP_WR_DIS: clr_wel = op8 && idle_ok;
          OP_SET_PARAMS: set_sel = quad_l && bit_cnt_ff == PRM_END;
          default: set_wel = 1'b0;
        endcase
      end
    end
  end

  // shared delay counter; sleep and write cycles never overlap
  logic [31:0] timer_ff;
  logic t_zero;
  assign t_zero = timer_ff == 32'h0;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff <= 32'h0;
    end else if (go_sleep) begin
      timer_ff <= 32'(SLEEP_ENTRY_CYC - 1);
    end else if (go_wake_code) begin
      timer_ff <= 32'(WAKE_CODE_CYC - 1);
    end else if (go_wake) begin
      timer_ff <= 32'(WAKE_CYC - 1);
    end else if (go_erase) begin
      timer_ff <= 32'(ERASE_CYCLES - 1);
    end else if (go_prog) begin
      timer_ff <= 32'(PROGRAM_CYCLES - 1);
    end else if (!t_zero) begin
      timer_ff <= timer_ff - 32'h1;
    end
  end

  // power state
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      PWR_ACTIVE: if (go_sleep) nxt_pwr = PWR_ENTERING;
      PWR_ENTERING: begin
        if (go_wake || go_wake_code) begin
          nxt_pwr = PWR_WAKING;
        end else if (t_zero) begin
          nxt_pwr = PWR_SLEEP;
        end
      end
      PWR_SLEEP: if (go_wake || go_wake_code) nxt_pwr = PWR_WAKING;
      PWR_WAKING: if (t_zero) nxt_pwr = PWR_ACTIVE;
      default: nxt_pwr = PWR_ACTIVE;
    endcase
    if (do_rst) begin
      nxt_pwr = PWR_ACTIVE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff <= PWR_ACTIVE;
      sleep_ff <= 1'b0;
      blk_ff <= 1'b0;
      waking_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      sleep_ff <= nxt_pwr == PWR_SLEEP;
      blk_ff <= nxt_pwr != PWR_ACTIVE;
      waking_ff <= nxt_pwr == PWR_WAKING;
    end
  end

  // self-timed cycle; erase also sweeps every byte to the erased value
  logic [11:0] erase_ptr_ff;
  logic sweep_done;
  assign sweep_done = erase_ptr_ff == MEM_LAST;
  always_comb begin
    nxt_cyc = cyc_ff;
    case (cyc_ff)
      CYC_IDLE: begin
        if (go_erase) begin
          nxt_cyc = CYC_ERASE;
        end else if (go_prog) begin
          nxt_cyc = CYC_PROG;
        end
      end
      CYC_ERASE: if (t_zero && sweep_done) nxt_cyc = CYC_IDLE;
      CYC_PROG: if (t_zero) nxt_cyc = CYC_IDLE;
      default: nxt_cyc = CYC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_ff <= CYC_IDLE;
      busy_ff <= 1'b0;
      erase_ptr_ff <= 12'h000;
    end else begin
      cyc_ff <= nxt_cyc;
      busy_ff <= nxt_cyc != CYC_IDLE;
      if (go_erase) begin
        erase_ptr_ff <= 12'h000;
      end else if (cyc_ff == CYC_ERASE && !sweep_done) begin
        erase_ptr_ff <= erase_ptr_ff + 12'h001;
      end
    end
  end

  // bytes are merged as they arrive; the busy cycle then times the write
  logic wr_ok;
  logic [1:0] wr_reg;
  assign wr_reg = addr_ff[13:12] - 2'h1;
  assign wr_ok = tgl_edge && wel_ff && cyc_ff == CYC_IDLE && pwr_ff == PWR_ACTIVE &&
    rd_region_ok && !lock_ff[wr_reg];
  always_ff @(posedge core_clk) begin
    // pointer parks on the last byte, so that byte is swept as well
    if (cyc_ff == CYC_ERASE) begin
      mem_ff[erase_ptr_ff] <= ERASED;
    end else if (wr_ok) begin
      mem_ff[{wr_reg, wr_off_ff}] <= mem_ff[{wr_reg, wr_off_ff}] & wr_data_ff;
    end
  end

  // write latch: dropped as a cycle starts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_ff <= 1'b0;
    end else if (go_erase || go_prog || clr_wel || do_rst) begin
      wel_ff <= 1'b0;
    end else if (set_wel) begin
      wel_ff <= 1'b1;
    end
  end

  // dummy setting and reset arming
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ff <= DUMMY_SEL_RST;
      rst_arm_ff <= 1'b0;
    end else begin
      if (do_rst) begin
        sel_ff <= DUMMY_SEL_RST;
      end else if (set_sel) begin
        sel_ff <= param_ff[5:4];
      end
      if (cs_rise) begin
        rst_arm_ff <= arm_rst;
      end
    end
  end

  // locks only ever accumulate; the stored copy is refilled after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= 3'h0;
      secure_ff <= 1'b0;
    end else begin
      lock_ff <= lock_ff | otp_lock_in | lock_set;
      secure_ff <= |(lock_ff | otp_lock_in | lock_set);
    end
  end

  assign busy_flag = busy_ff;
  assign write_unlock_latch = wel_ff;
  assign deep_sleep_state = sleep_ff;
  assign per_region_lock_bits = lock_ff;
  assign secure_area_lock = secure_ff;
endmodule
`default_nettype wire

// *** tb/fis_flash_cmd_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module fis_flash_cmd_props #(
  parameter int PROGRAM_CYCLES = fis_pkg::PROGRAM_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  // configuration and locks
  input wire logic four_line_command_mode,
  input wire logic [2:0] otp_lock_in,
  input wire logic [2:0] lock_set,
  // status
  input wire logic busy_flag,
  input wire logic write_unlock_latch,
  input wire logic deep_sleep_state,
  input wire logic [2:0] per_region_lock_bits,
  input wire logic secure_area_lock
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // busy length counter
  // ----------------------------------------
  logic [31:0] busy_len_ff; // cycles busy has stood so far
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_len_ff <= 32'h0;
    end else if (busy_flag) begin
      busy_len_ff <= busy_len_ff + 32'h1;
    end else begin
      busy_len_ff <= 32'h0;
    end
  end
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_link_quiet;
    (io_oe == 4'h0)[*8];
  endsequence
  sequence s_cycle_start;
    $rose(busy_flag);
  endsequence
  property p_oe_released; cs_n |-> io_oe == 4'h0; endproperty
  property p_busy_needs_latch; s_cycle_start |-> $past(write_unlock_latch); endproperty
  property p_latch_dropped; $fell(busy_flag) |-> !write_unlock_latch; endproperty
  property p_busy_len; $fell(busy_flag) |-> busy_len_ff >= 32'(PROGRAM_CYCLES - 1); endproperty
  property p_busy_after_rise; s_cycle_start |-> cs_n && $past(cs_n, 2); endproperty
  property p_sleep_idle; deep_sleep_state |-> !busy_flag; endproperty
  property p_sleep_entry; $rose(deep_sleep_state) |-> cs_n && $past(cs_n, 8); endproperty
  property p_wake_quiet; $fell(deep_sleep_state) |-> s_link_quiet; endproperty
  property p_lock_sticky; ##1 ($past(per_region_lock_bits) & ~per_region_lock_bits) == 3'h0;
  endproperty
  property p_lock_set; lock_set[0] |-> ##[1:4] per_region_lock_bits[0] && secure_area_lock;
  endproperty
  a_oe_released: assert property (p_oe_released) else $error("output enabled while deselected");
  a_busy_needs_latch: assert property (p_busy_needs_latch) else $error("cycle without latch");
  a_latch_dropped: assert property (p_latch_dropped) else $error("latch kept after cycle");
  a_busy_len: assert property (p_busy_len) else $error("self-timed cycle too short");
  a_busy_after_rise: assert property (p_busy_after_rise) else $error("cycle began in frame");
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleeping while busy");
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered too early");
  a_wake_quiet: assert property (p_wake_quiet) else $error("lines driven while waking");
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");
  a_lock_set: assert property (p_lock_set) else $error("lock request not taken");
endmodule
bind fis_flash_cmd fis_flash_cmd_props #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) props_u (
  .core_clk(core_clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
  .io_out(io_out), .io_oe(io_oe), .four_line_command_mode(four_line_command_mode),
  .otp_lock_in(otp_lock_in), .lock_set(lock_set), .busy_flag(busy_flag),
  .write_unlock_latch(write_unlock_latch), .deep_sleep_state(deep_sleep_state),
  .per_region_lock_bits(per_region_lock_bits), .secure_area_lock(secure_area_lock));
`default_nettype wire

// *** tb/fis_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module fis_host (
  // toward the device
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in,
  // back from the device
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  // line mode the device was told to use
  input wire logic quad
);
  // link clock parks low between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h5;
  end
  // one frame, 32 ns link clock: nt clocks out, then nr clocks back
  task automatic frame(input logic [63:0] tx, input int nt, input int nr,
                       output logic [127:0] rx);
    rx = '0;
    #16 cs_n = 1'b0;
    for (int i = 0; i < nt + nr; i++) begin
      if (quad) begin
        io_in = (i < nt) ? tx[4*(nt-1-i) +: 4] : ~io_in;
      end else begin
        io_in[0] = (i < nt) ? tx[nt-1-i] : ~io_in[0];
      end
      #16 sclk = 1'b1;
      // released data lines are pulled up, so silence reads as ones
      if (i >= nt && quad) rx = {rx[123:0], io_oe[0] ? io_out : 4'hf};
      if (i >= nt && !quad) rx = {rx[126:0], io_oe[1] ? io_out[1] : 1'b1};
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    io_in = ~io_in;
    #240;
  endtask
endmodule
`default_nettype wire

// *** tb/fis_flash_cmd_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module fis_flash_cmd_tb_top;
  import fis_pkg::*;
  // ----------------------------------------
  // short self-timed cycles keep the run brief
  // ----------------------------------------
  localparam int ER_CYC = 4000;
  localparam int PG_CYC = 20;
  localparam logic [7:0] MK = 8'h5e; // arbitrary value
  localparam logic [7:0] TY = 8'h62; // arbitrary value
  localparam logic [7:0] CP = 8'h17; // arbitrary value
  localparam logic [7:0] DC = 8'h33; // arbitrary value
  localparam logic [127:0] UN = 128'h00112233_44556677_8899aabb_ccddeeff; // arbitrary value
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic four_line_command_mode = 1'b0; // single-line until the last scenario
  logic [2:0] otp_lock_in = 3'h0;
  logic [2:0] lock_set = 3'h0;
  logic sclk, cs_n, busy_flag, write_unlock_latch, deep_sleep_state, secure_area_lock;
  logic [3:0] io_in, io_out, io_oe;
  logic [2:0] per_region_lock_bits;
  logic [127:0] rx;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  always #10 core_clk = ~core_clk;
  fis_flash_cmd #(.ERASE_CYCLES(ER_CYC), .PROGRAM_CYCLES(PG_CYC), .MAKER_CODE(MK),
    .MEM_TYPE(TY), .CAPACITY(CP), .DEVICE_CODE(DC), .UNIQUE_NUM(UN)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .four_line_command_mode(four_line_command_mode),
    .otp_lock_in(otp_lock_in), .lock_set(lock_set), .busy_flag(busy_flag),
    .write_unlock_latch(write_unlock_latch), .deep_sleep_state(deep_sleep_state),
    .per_region_lock_bits(per_region_lock_bits), .secure_area_lock(secure_area_lock));
  fis_host host_u (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .quad(four_line_command_mode));
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic f(input logic [63:0] tx, input int nt, input int nr);
    host_u.frame(tx, nt, nr, rx);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // bounded wait for the self-timed cycle to finish
  task automatic wait_idle;
    for (int i = 0; i < ER_CYC + 8000 && busy_flag !== 1'b0; i++) @(posedge core_clk);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ids;
    f(64'h9f, 8, 40); chk(rx[39:0], {MK, TY, CP, 8'h00, MK});
    f(64'h9f, 8, 5); chk(rx[4:0], MK[7:3]);
    f(64'h4b00000000, 40, 128); chk(rx, UN);
    f(64'hab000000, 32, 16); chk(rx[15:0], {DC, DC});
    f(64'h5a00000400, 40, 32); chk(rx[31:0], PARAM_TABLE[95:64]);
    $display("t_ids done");
  endtask
  task automatic t_sleep;
    f(64'h172, 9, 0); cyc(SLEEP_ENTRY_CYC + 10); chk(deep_sleep_state, 1'b0);
    f(64'hb9, 8, 0); cyc(SLEEP_ENTRY_CYC + 10); chk(deep_sleep_state, 1'b1);
    f(64'h4b00000000, 40, 32); chk(rx[31:0], 32'hffffffff);
    f(64'h05, 8, 8); chk(rx[7:0], 8'hff);
    f(64'hab, 8, 0); cyc(WAKE_CYC + 10); chk(deep_sleep_state, 1'b0);
    f(64'h9f, 8, 8); chk(rx[7:0], MK);
    f(64'hb9, 8, 0); cyc(SLEEP_ENTRY_CYC + 10);
    f(64'hab000000, 32, 8); chk(rx[7:0], DC);
    cyc(WAKE_CODE_CYC + 10); f(64'h9f, 8, 8); chk(rx[7:0], MK);
    $display("t_sleep done");
  endtask
  task automatic t_erase;
    f(64'h44, 8, 0); cyc(10); chk(busy_flag, 1'b0);
    f(64'h06, 8, 0); chk(write_unlock_latch, 1'b1);
    f(64'h44, 8, 0); chk({busy_flag, write_unlock_latch}, 2'b10);
    f(64'h9f, 8, 32); chk(rx[31:0], 32'hffffffff);
    f(64'hab000000, 32, 8); chk(rx[7:0], 8'hff);
    f(64'h05, 8, 8); chk(rx[7:0], 8'h01);
    wait_idle(); chk(busy_flag, 1'b0);
    $display("t_erase done");
  endtask
  task automatic t_prog;
    f(64'h06, 8, 0); f(64'h420013ffa5, 40, 0); wait_idle();
    chk(write_unlock_latch, 1'b0);
    f(64'h480013ff00, 40, 16); chk(rx[15:0], 16'ha5ff);
    f(64'h06, 8, 0); f(64'h420030053c, 40, 0); wait_idle();
    f(64'h4800300500, 40, 8); chk(rx[7:0], 8'h3c);
    f(64'h4800200500, 40, 8); chk(rx[7:0], 8'hff);
    $display("t_prog done");
  endtask
  task automatic t_lock;
    cyc(1);
    lock_set <= 3'h1;
    cyc(1);
    lock_set <= 3'h0;
    otp_lock_in <= 3'h4;
    cyc(6); chk({per_region_lock_bits, secure_area_lock}, 4'b1011);
    f(64'h06, 8, 0); f(64'h44, 8, 0); chk(busy_flag, 1'b0);
    f(64'h4200100011, 40, 0); wait_idle();
    f(64'h4800100000, 40, 8); chk(rx[7:0], 8'hff);
    $display("t_lock done");
  endtask
  // four-line reads, default and configured dummy clocks
  task automatic t_quad;
    cyc(1);
    four_line_command_mode <= 1'b1;
    cyc(1);
    f(64'h0, 2, 0); // two idle clocks let the link side see the new mode
    f(64'h5a0000000000, 12, 4); chk(rx[15:0], PARAM_TABLE[127:112]);
    f(64'hc020, 4, 0);
    f(64'h5a00000000000000, 16, 4); chk(rx[15:0], PARAM_TABLE[127:112]);
    $display("t_quad done");
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      end_of_test();
    end
  end
  initial begin
    cyc(4);
    arst_n <= 1'b1;
    cyc(6);
    t_ids();
    t_sleep();
    t_erase();
    t_prog();
    t_lock();
    t_quad();
    end_of_test();
  end
endmodule
`default_nettype wire
